//--- verilog/dhb_bridge.sv
// signal processor memory decode, dma master and shared control register
`include "dhb_cfg.svh"

// Summary of operation
// - rom at program 0000-3fff, ram at program 4000-7fff and data 0000-7fff, aliased.
// - global access 8000-ffff raises dma request, waits for grant before host cycle.
// - on grant host floats bus; bridge drives address, status and byte mask.
// - assert address strobe, drop address drive, then data strobe and transceivers.
// - host ready raises dma done ready, which gives processor ready.
// - dma read data latched at ready, held on processor bus until cycle ends.
// - at end of access drop address strobe, data strobe, request and transceivers.
// - ram read picks bank by low address bit, selects it, no write strobes.
// - on processor read strobe all ram outputs on; ready with no wait states on any strobe.
// - ram write asserts selected bank write strobes with processor strobe.
// - rom read only; select on rom address, output enable with read strobe.
// - rom access gets three wait states, then dma done ready and processor ready.
// - low eight control bits are mailbox; processor reads host byte only.
// - processor io write latches its byte when write latch pulse falls.
// - processor io write data bit 8 sets host interrupt, drives host irq line.
// - host reads processor byte; host write seen at next processor read.
// - reset clears control bits except hold and reset, which come up set.
// - processor starts at 0000 in rom, loads by dma, runs from 4000.
// - host acknowledge drops irq but keeps bit; host control read clears bit.
// - processor interrupt bit drives irq input 0, cleared by processor acknowledge.
// - processor cannot read control bits above the mailbox, only writes host interrupt bit.
// - host base register picks 64k-byte block, driven during dma addressing.
module dhb_bridge
   import dhb_pkg::*;
(
   // clock and reset
   input  wire logic             mclk_i,
   input  wire logic             nrst_i,
   // signal processor bus
   input  wire dhb_proc_req_type proc_req_i,
   input  wire logic             proc_iack_i,
   output logic                  proc_ready_o,
   output logic [15:0]           proc_rdata_o,
   output logic                  proc_rdata_oe_o,
   output logic                  coproc_irq_o,
   output logic                  proc_hold_o,
   output logic                  proc_reset_o,
   // private memory decode
   output logic                  ram_bank0_sel_o,
   output logic                  ram_bank1_sel_o,
   output logic                  ram_output_en_o,
   output logic [1:0]            ram_write_strobes_o,
   output logic                  rom_select_o,
   output logic                  rom_output_en_o,
   // host bus
   input  wire logic             host_dma_grant_n_i,
   input  wire logic             host_rdy_n_i,
   input  wire logic [31:0]      host_muxed_bus_i,
   output logic                  host_dma_request_n_o,
   output logic [31:0]           host_muxed_bus_o,
   output logic                  host_muxed_bus_oe_n_o,
   output logic                  address_strobe_n_o,
   output logic                  data_strobe_n_o,
   output logic [3:0]            byte_lane_mask_n_o,
   output logic [2:0]            cycle_status_n_o,
   output logic                  host_irq2_n_o,
   // host register port
   input  wire dhb_host_csr_type host_csr_i,
   input  wire dhb_host_csr_type host_base_i,
   input  wire logic             host_iack_i,
   input  wire logic             host_set_coproc_irq_i,
   input  wire logic             host_hold_wr_i,
   input  wire logic             host_hold_i,
   input  wire logic             host_reset_wr_i,
   input  wire logic             host_reset_i,
   output logic [7:0]            host_mbox_rdata_o,
   output logic                  host_irq_bit_o,
   output logic [15:0]           host_base_rdata_o
);

   dhb_dma_state_type state_r;
   dhb_proc_req_type  req_s1_r;
   dhb_proc_req_type  req_r;
   logic       grant_s1_r;
   logic       grant_r;
   logic       rdy_s1_r;
   logic       rdy_r;
   logic       iack_s1_r;
   logic       iack_r;
   logic       dma_done_rdy_r;
   logic [1:0] rom_wait_r;
   logic       rom_rdy_r;
   logic       latch_r;
   logic [7:0] proc_mbox_r;
   logic [7:0] host_mbox_r;
   logic       host_irq_bit_r;
   logic       host_irq_req_r;
   logic       coproc_irq_r;
   logic       hold_r;
   logic       reset_r;
   logic [7:0] base_r;
   logic [15:0] dma_rdata_r;
   logic       global_acc;
   logic       ram_acc;
   logic       rom_acc;
   logic       io_acc;
   logic       mbox_write_latch;
   logic       end_cycle;

   // external strobes pass two flip-flops before decode
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         req_s1_r   <= '0;
         req_r      <= '0;
         grant_s1_r <= 1'b0;
         grant_r    <= 1'b0;
         rdy_s1_r   <= 1'b0;
         rdy_r      <= 1'b0;
         iack_s1_r  <= 1'b0;
         iack_r     <= 1'b0;
      end
      else
      begin
         req_s1_r   <= proc_req_i;
         req_r      <= req_s1_r;
         grant_s1_r <= !host_dma_grant_n_i;
         grant_r    <= grant_s1_r;
         rdy_s1_r   <= !host_rdy_n_i;
         rdy_r      <= rdy_s1_r;
         iack_s1_r  <= proc_iack_i;
         iack_r     <= iack_s1_r;
      end
   end

   assign io_acc     = req_r.io_space;
   assign global_acc = !io_acc && req_r.addr[`DHB_GLOBAL_BIT];
   assign rom_acc    = !io_acc && !global_acc && req_r.prog_space
                       && !req_r.addr[`DHB_ROM_PS_BIT];
   assign ram_acc    = !io_acc && !global_acc && !rom_acc;
   assign end_cycle  = !req_r.strobe;

   // bank select from low address bit
   assign ram_bank0_sel_o = ram_acc && !req_r.addr[0];
   assign ram_bank1_sel_o = ram_acc && req_r.addr[0];
   assign ram_output_en_o = ram_acc && req_r.strobe && !req_r.write;
   assign ram_write_strobes_o = (ram_acc && req_r.strobe && req_r.write)
                                ? {req_r.addr[0], !req_r.addr[0]} : 2'b00;
   assign rom_select_o    = rom_acc;
   assign rom_output_en_o = rom_acc && req_r.strobe && !req_r.write;

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rom_wait_r <= 2'd0;
         rom_rdy_r  <= 1'b0;
      end
      else if (!(rom_acc && req_r.strobe))
      begin
         rom_wait_r <= 2'd0;
         rom_rdy_r  <= 1'b0;
      end
      else if (rom_wait_r != 2'(`DHB_ROM_WAIT_CYC))
         rom_wait_r <= rom_wait_r + 2'd1;
      else
         rom_rdy_r  <= 1'b1;
   end

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         state_r <= DHB_IDLE;
      else
      begin
         unique case (state_r)
            DHB_IDLE: if (global_acc && req_r.strobe) state_r <= DHB_REQ;
            DHB_REQ:  if (grant_r) state_r <= DHB_ADDR;
            DHB_ADDR: state_r <= DHB_ASTB;
            DHB_ASTB: state_r <= DHB_DATA;
            DHB_DATA: if (rdy_r) state_r <= DHB_DONE;
            DHB_DONE: if (end_cycle) state_r <= DHB_IDLE;
         endcase
      end
   end

   // done ready from host ready or rom wait end
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         dma_done_rdy_r <= 1'b0;
      else
         dma_done_rdy_r <= (state_r == DHB_DATA && rdy_r) || state_r == DHB_DONE
                           || rom_rdy_r;
   end

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         dma_rdata_r <= 16'h0000;
      else if (state_r == DHB_DATA && rdy_r && !req_r.write)
         dma_rdata_r <= req_r.addr[0] ? host_muxed_bus_i[31:16] : host_muxed_bus_i[15:0];
   end

   // io ready must follow the strobe, or ready never drops between mailbox accesses
   assign proc_ready_o = ((ram_acc || io_acc) && req_r.strobe) || dma_done_rdy_r;
   assign proc_rdata_o = io_acc ? {8'h00, host_mbox_r} : dma_rdata_r;
   assign proc_rdata_oe_o = req_r.strobe && !req_r.write
                            && (io_acc || (global_acc && state_r == DHB_DONE));

   // address is base block plus word offset
   always_comb
   begin
      host_muxed_bus_o = 32'h0000_0000;
      if (state_r == DHB_ADDR || state_r == DHB_ASTB)
         host_muxed_bus_o = {8'h00, base_r, req_r.addr[14:1], 2'b00};
      else if (state_r == DHB_DATA || state_r == DHB_DONE)
         host_muxed_bus_o = {req_r.wdata, req_r.wdata};
   end
   // request and strobes tied to state
   assign host_dma_request_n_o  = (state_r == DHB_IDLE);
   assign host_muxed_bus_oe_n_o = !((state_r == DHB_ADDR) || (state_r == DHB_ASTB)
                                 || ((state_r == DHB_DATA || state_r == DHB_DONE)
                                     && req_r.write));
   assign address_strobe_n_o = !(state_r == DHB_ASTB || state_r == DHB_DATA
                                 || state_r == DHB_DONE);
   assign data_strobe_n_o    = !(state_r == DHB_DATA || state_r == DHB_DONE);
   assign byte_lane_mask_n_o = req_r.addr[0] ? 4'b0011 : 4'b1100;
   assign cycle_status_n_o   = req_r.write ? 3'b110 : 3'b101;

   // latch on fall of write latch pulse
   assign mbox_write_latch = io_acc && req_r.write && req_r.strobe;
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         latch_r <= 1'b0;
      else
         latch_r <= mbox_write_latch;
   end

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         proc_mbox_r <= `DHB_MBOX_RST;
      else if (latch_r && !mbox_write_latch)
         proc_mbox_r <= req_r.wdata[7:0];
   end

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         host_mbox_r <= `DHB_MBOX_RST;
      else if (host_csr_i.write)
         host_mbox_r <= host_csr_i.wdata;
   end

   // bit 8 sets host irq; set wins over clear
   // acknowledge drops line, host read clears bit
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         host_irq_bit_r <= 1'b0;
         host_irq_req_r <= 1'b0;
      end
      else if (latch_r && !mbox_write_latch && req_r.wdata[`DHB_HIRQ_BIT])
      begin
         host_irq_bit_r <= 1'b1;
         host_irq_req_r <= 1'b1;
      end
      else
      begin
         if (host_csr_i.read)
            host_irq_bit_r <= 1'b0;
         if (host_iack_i || host_csr_i.read)
            host_irq_req_r <= 1'b0;
      end
   end

   // processor interrupt cleared by its acknowledge
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         coproc_irq_r <= 1'b0;
      else if (host_set_coproc_irq_i)
         coproc_irq_r <= 1'b1;
      else if (iack_r)
         coproc_irq_r <= 1'b0;
   end

   // hold and reset come up set
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         hold_r  <= `DHB_CSR_RST_HOLD;
         reset_r <= `DHB_CSR_RST_RESET;
         base_r  <= 8'h00;
      end
      else
      begin
         if (host_hold_wr_i)
            hold_r <= host_hold_i;
         if (host_reset_wr_i)
            reset_r <= host_reset_i;
         if (host_base_i.write)
            base_r <= host_base_i.wdata;
      end
   end

   // processor held until host releases it
   assign proc_hold_o       = hold_r;
   assign proc_reset_o      = reset_r;
   assign coproc_irq_o      = coproc_irq_r;
   assign host_irq2_n_o     = !host_irq_req_r;
   assign host_irq_bit_o    = host_irq_bit_r;
   assign host_mbox_rdata_o = proc_mbox_r;
   assign host_base_rdata_o = {base_r, 8'h00};

   rom_wait_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $rose(rom_rdy_r) |-> $past(rom_wait_r) == 2'd3)
      else $error("rom ready before three wait states");
   dma_req_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $fell(host_dma_request_n_o) |-> $past(global_acc && req_r.strobe))
      else $error("dma request without global access");
   strobe_order_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $fell(data_strobe_n_o) |-> !address_strobe_n_o && $past(!address_strobe_n_o))
      else $error("data strobe before address strobe");
   hold_reset_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $rose(nrst_i) |-> proc_hold_o && proc_reset_o)
      else $error("hold not set after reset");
   read_hold_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      state_r == DHB_DONE && $past(state_r) == DHB_DONE |-> $stable(dma_rdata_r))
      else $error("dma read data changed before cycle end");
   dma_end_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      state_r == DHB_DONE && end_cycle |=> host_dma_request_n_o && address_strobe_n_o
         && data_strobe_n_o && host_muxed_bus_oe_n_o)
      else $error("dma lines still active after access end");
   host_irq_set_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      latch_r && !mbox_write_latch && req_r.wdata[`DHB_HIRQ_BIT] |=> !host_irq2_n_o)
      else $error("host interrupt not raised by processor write");
endmodule // dhb_bridge

//--- verilog/dhb_cfg.svh
// constants for the signal processor to host dma bridge
`ifndef DHB_CFG_SVH
`define DHB_CFG_SVH
`define DHB_GLOBAL_BIT      15
`define DHB_ROM_PS_BIT      14
`define DHB_MBOX_W          8
`define DHB_HIRQ_BIT        8
`define DHB_BASE_W          16
`define DHB_CLK_NS          50
`define DHB_ROM_WAIT_STATES 3
`define DHB_ROM_WAIT_CYC    (`DHB_ROM_WAIT_STATES)
`define DHB_CSR_RST_HOLD    1'b1
`define DHB_CSR_RST_RESET   1'b1
`define DHB_MBOX_RST        8'h00
`endif

//--- verilog/dhb_pkg.sv
// types for the signal processor to host dma bridge
package dhb_pkg;
   typedef enum logic [2:0] {
      DHB_IDLE,
      DHB_REQ,
      DHB_ADDR,
      DHB_ASTB,
      DHB_DATA,
      DHB_DONE
   } dhb_dma_state_type;

   typedef struct packed {
      logic        strobe;
      logic        write;
      logic        prog_space;
      logic        io_space;
      logic [15:0] addr;
      logic [15:0] wdata;
   } dhb_proc_req_type;

   typedef struct packed {
      logic       write;
      logic       read;
      logic [7:0] wdata;
   } dhb_host_csr_type;
endpackage

//--- sim/dhb_host_model.sv
// host bus model that grants dma, answers with ready and returns read data
module dhb_host_model
(
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        nrst_i,
   // bridge side of the host bus
   input  wire logic        request_n_i,
   input  wire logic        as_n_i,
   input  wire logic        ds_n_i,
   input  wire logic [31:0] bus_i,
   input  wire logic [3:0]  mask_n_i,
   // behaviour chosen by the bench
   input  wire logic [3:0]  wait_i,
   input  wire logic [31:0] word_i,
   // host answers and what it saw
   output logic             grant_n_o,
   output logic             rdy_n_o,
   output logic [31:0]      bus_o,
   output logic [31:0]      seen_addr_o,
   output logic [3:0]       seen_mask_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_r;
   logic       as_q_r;
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         grant_n_o   <= 1'b1;
         rdy_n_o     <= 1'b1;
         wait_r      <= 4'h0;
         as_q_r      <= 1'b1;
         bus_o       <= 32'h0000_0000;
         seen_addr_o <= 32'h0000_0000;
         seen_mask_o <= 4'h0;
      end
      else
      begin
         as_q_r <= as_n_i;
         // released lines toggle so a stale word can never pass
         if (rdy_n_o)
            bus_o <= ~bus_o;
         if (request_n_i)
         begin
            grant_n_o <= 1'b1;
            wait_r    <= 4'h0;
         end
         else if (grant_n_o)
         begin
            wait_r <= wait_r + 4'h1;
            if (wait_r >= wait_i)
            begin
               grant_n_o <= 1'b0;
               wait_r    <= 4'h0;
            end
         end
         if (as_q_r && !as_n_i)
         begin
            seen_addr_o <= bus_i;
            seen_mask_o <= mask_n_i;
         end
         // ready only inside the data strobe, held until it rises
         if (ds_n_i)
            rdy_n_o <= 1'b1;
         else if (rdy_n_o)
         begin
            wait_r <= wait_r + 4'h1;
            if (wait_r >= wait_i)
            begin
               rdy_n_o <= 1'b0;
               bus_o   <= word_i;
            end
         end
      end
   end
endmodule // dhb_host_model

//--- sim/dhb_bridge_test.sv
// self-checking bench for the bridge with a host bus model
module dhb_bridge_test
   import dhb_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic p; logic w; logic [15:0] a; logic b0, b1, rom;} dhb_row_type;
   logic mclk_i, nrst_i, proc_iack_i, proc_ready_o, proc_rdata_oe_o, coproc_irq_o, proc_hold_o;
   logic proc_reset_o, ram_bank0_sel_o, ram_bank1_sel_o, ram_output_en_o, rom_select_o;
   logic rom_output_en_o, host_dma_grant_n_i, host_rdy_n_i, host_dma_request_n_o;
   logic host_muxed_bus_oe_n_o, address_strobe_n_o, data_strobe_n_o, host_irq2_n_o;
   logic host_iack_i, host_set_coproc_irq_i, host_hold_wr_i, host_hold_i, host_reset_wr_i;
   logic host_reset_i, host_irq_bit_o;
   logic [1:0]  ram_write_strobes_o;
   logic [2:0]  cycle_status_n_o;
   logic [3:0]  byte_lane_mask_n_o, grant_wait, seen_mask;
   logic [7:0]  host_mbox_rdata_o;
   logic [15:0] proc_rdata_o, host_base_rdata_o;
   logic [31:0] host_muxed_bus_i, host_muxed_bus_o, read_word, seen_addr;
   dhb_proc_req_type proc_req_i;
   dhb_host_csr_type host_csr_i, host_base_i;
   int n_errors = 0;
   int checked = 0;
   dhb_row_type rows [6] = '{'{0, 0, 16'h0004, 1, 0, 0}, '{0, 0, 16'h7FFF, 0, 1, 0},
      '{1, 0, 16'h4002, 1, 0, 0}, '{0, 1, 16'h1001, 0, 1, 0}, '{1, 1, 16'h5000, 1, 0, 0},
      '{1, 0, 16'h0000, 0, 0, 1}};

   dhb_bridge dut_u (.mclk_i, .nrst_i, .proc_req_i, .proc_iack_i, .proc_ready_o, .proc_rdata_o,
      .proc_rdata_oe_o, .coproc_irq_o, .proc_hold_o, .proc_reset_o, .ram_bank0_sel_o,
      .ram_bank1_sel_o, .ram_output_en_o, .ram_write_strobes_o, .rom_select_o, .rom_output_en_o,
      .host_dma_grant_n_i, .host_rdy_n_i, .host_muxed_bus_i, .host_dma_request_n_o,
      .host_muxed_bus_o, .host_muxed_bus_oe_n_o, .address_strobe_n_o, .data_strobe_n_o,
      .byte_lane_mask_n_o, .cycle_status_n_o, .host_irq2_n_o, .host_csr_i, .host_base_i,
      .host_iack_i, .host_set_coproc_irq_i, .host_hold_wr_i, .host_hold_i, .host_reset_wr_i,
      .host_reset_i, .host_mbox_rdata_o, .host_irq_bit_o, .host_base_rdata_o);
   dhb_host_model host_u (.mclk_i, .nrst_i, .request_n_i(host_dma_request_n_o),
      .as_n_i(address_strobe_n_o), .ds_n_i(data_strobe_n_o), .bus_i(host_muxed_bus_o),
      .mask_n_i(byte_lane_mask_n_o), .wait_i(grant_wait), .word_i(read_word),
      .grant_n_o(host_dma_grant_n_i), .rdy_n_o(host_rdy_n_i), .bus_o(host_muxed_bus_i),
      .seen_addr_o(seen_addr), .seen_mask_o(seen_mask));

   task automatic give_verdict;
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic c, input string m);
      checked++;
      if (c !== 1'b1)
      begin
         n_errors++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   // holds the request until ready is seen high at a sampling point
   task automatic acc(input logic p, io, w, input logic [15:0] a, d, output int lat);
      lat = 0;
      proc_req_i = '{1'b1, w, p, io, a, d};
      while (proc_ready_o !== 1'b1 && lat < 200)
      begin
         @(negedge mclk_i);
         lat++;
      end
   endtask
   task automatic rel;
      int k;
      k = 0;
      proc_req_i.strobe = 1'b0;
      while (proc_ready_o !== 1'b0 && k < 20)
      begin
         @(negedge mclk_i);
         k++;
      end
      chk(k < 20, "ready stuck");
      repeat (3) @(negedge mclk_i);
   endtask
   task automatic pulse(input dhb_host_csr_type c, b, input logic [3:0] p);
      host_csr_i = c;
      host_base_i = b;
      {host_iack_i, host_set_coproc_irq_i, host_hold_wr_i, host_reset_wr_i} = p;
      @(negedge mclk_i);
      host_csr_i = '0;
      host_base_i = '0;
      {host_iack_i, host_set_coproc_irq_i, host_hold_wr_i, host_reset_wr_i} = 4'h0;
      @(negedge mclk_i);
   endtask
   task automatic dma(input logic w, input logic [15:0] a, input logic [3:0] gw);
      int lat;
      logic [15:0] exp;
      exp = a[0] ? read_word[31:16] : read_word[15:0];
      grant_wait = gw;
      fork
         acc(1'b0, 1'b0, w, a, 16'hBEEF, lat);
         begin
            repeat (6) @(negedge mclk_i);
            if (gw > 4'd8)
               chk(host_dma_request_n_o === 1'b0 && address_strobe_n_o === 1'b1, "early");
         end
      join
      chk(lat < 200, "no dma ready");
      chk(seen_addr === {8'h00, 8'h3C, a[14:1], 2'b00}, "dma address");
      chk(seen_mask === (a[0] ? 4'b0011 : 4'b1100), "byte mask");
      chk(cycle_status_n_o === (w ? 3'b110 : 3'b101), "cycle status");
      chk(host_muxed_bus_oe_n_o === !w, "data drive");
      chk(!w || host_muxed_bus_o === {2{16'hBEEF}}, "write data");
      repeat (3) @(negedge mclk_i);
      chk(proc_ready_o === 1'b1 && (w || proc_rdata_o === exp), "read data");
      chk(proc_rdata_oe_o === !w, "read drive");
      rel();
      chk((host_dma_request_n_o & address_strobe_n_o & data_strobe_n_o) === 1'b1, "end");
      chk(host_muxed_bus_oe_n_o === 1'b1, "bus released");
   endtask

   initial
   begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end
   initial
   begin
      repeat (3000) @(negedge mclk_i);
      n_errors++;
      $display("ERROR %0t watchdog expired", $time);
      give_verdict();
   end
   initial
   begin
      int lat;
      int base_lat;
      nrst_i = 1'b0;
      proc_req_i = '0;
      proc_iack_i = 1'b0;
      host_csr_i = '0;
      host_base_i = '0;
      {host_iack_i, host_set_coproc_irq_i, host_hold_wr_i, host_reset_wr_i} = 4'h0;
      host_hold_i = 1'b0;
      host_reset_i = 1'b0;
      grant_wait = 4'd1;
      read_word = 32'hC3A5_5A3C;
      repeat (16) @(negedge mclk_i);
      chk(proc_hold_o === 1'b1 && proc_reset_o === 1'b1 && host_irq2_n_o === 1'b1, "rst");
      chk(host_mbox_rdata_o === 8'h00 && coproc_irq_o === 1'b0, "reset clear");
      nrst_i = 1'b1;
      @(negedge mclk_i);
      pulse('0, '{1'b1, 1'b0, 8'h3C}, 4'h3);
      chk(proc_hold_o === 1'b0 && proc_reset_o === 1'b0, "hold release");
      chk(host_base_rdata_o === 16'h3C00, "base readback");
      for (int i = 0; i < $size(rows); i++)
      begin
         acc(rows[i].p, 1'b0, rows[i].w, rows[i].a, 16'h1234, lat);
         if (i == 0)
            base_lat = lat;
         chk(ram_bank0_sel_o === rows[i].b0 && ram_bank1_sel_o === rows[i].b1, "bank");
         chk((ram_write_strobes_o !== 2'b00) === rows[i].w, "write strobe");
         chk(rom_select_o === rows[i].rom && rom_output_en_o === rows[i].rom, "rom");
         if (rows[i].rom)
            chk(lat >= base_lat + `DHB_ROM_WAIT_CYC, "rom wait");
         else
            chk(lat <= 3 && (ram_output_en_o === 1'b1 || rows[i].w), "ram wait");
         rel();
      end
      pulse('{1'b1, 1'b0, 8'h5A}, '0, 4'h0);
      acc(1'b0, 1'b1, 1'b1, 16'h0000, 16'h01A5, lat);
      rel();
      chk(host_mbox_rdata_o === 8'hA5, "mailbox to host");
      chk(host_irq2_n_o === 1'b0 && host_irq_bit_o === 1'b1, "host irq");
      acc(1'b0, 1'b1, 1'b0, 16'h0000, 16'h0000, lat);
      chk(proc_rdata_o === 16'h005A && proc_rdata_oe_o === 1'b1, "mailbox read");
      rel();
      pulse('0, '0, 4'h8);
      chk(host_irq2_n_o === 1'b1 && host_irq_bit_o === 1'b1, "host ack");
      pulse('{1'b0, 1'b1, 8'h00}, '0, 4'h0);
      chk(host_irq_bit_o === 1'b0, "read clears");
      acc(1'b0, 1'b1, 1'b1, 16'h0000, 16'h0033, lat);
      rel();
      chk(host_mbox_rdata_o === 8'h33 && host_irq2_n_o === 1'b1, "no irq");
      pulse('0, '0, 4'h4);
      chk(coproc_irq_o === 1'b1, "coproc irq");
      proc_iack_i = 1'b1;
      repeat (4) @(negedge mclk_i);
      proc_iack_i = 1'b0;
      chk(coproc_irq_o === 1'b0, "coproc ack");
      dma(1'b0, 16'h8004, 4'd1);
      dma(1'b1, 16'hC123, 4'd12);
      dma(1'b0, 16'hFFFF, 4'd12);
      nrst_i = 1'b0;
      @(negedge mclk_i);
      chk(proc_hold_o === 1'b1 && proc_reset_o === 1'b1, "second reset");
      nrst_i = 1'b1;
      give_verdict();
   end
endmodule // dhb_bridge_test
